//--- rtl/pde_pkg.sv
// Constants shared by the port D/E alternate function override block.
package pde_pkg;

    // Pin counts and the position of port E inside the combined pin vector.
    localparam int PIN_COUNT = 10;
    localparam int D_WIDTH = 2;
    localparam int E_WIDTH = 8;
    localparam int E_BASE = 2;

    // Port D bit positions.
    localparam int D_CAPTURE = 0;
    localparam int D_EXT_IRQ = 1;

    // Port E bit positions.
    localparam int E_RX = 0;
    localparam int E_TX = 1;
    localparam int E_XCLK = 2;
    localparam int E_CMP_NEG = 3;
    localparam int E_USI_CLK = 4;
    localparam int E_USI_DIN = 5;
    localparam int E_USI_DOUT = 6;
    localparam int E_CLK_OUT = 7;

    // Values after reset.
    localparam logic [1:0] RST_D = 2'h0;
    localparam logic [7:0] RST_E = 8'h00;
    localparam logic RST_BIT = 1'b0;

endpackage : pde_pkg

//--- rtl/pde_pin_mux.sv
// Per-pin override multiplexer choosing between port registers and peripheral overrides.
`timescale 1ns/1ps
`default_nettype none

module pde_pin_mux (
    // Ordinary port register state.
    input wire logic port_out,
    input wire logic port_dir,
    input wire logic pull_off,
    input wire logic din_base,
    // Override enables and values.
    input wire logic pu_oe,
    input wire logic pu_ov,
    input wire logic dd_oe,
    input wire logic dd_ov,
    input wire logic pv_oe,
    input wire logic pv_ov,
    input wire logic die_oe,
    input wire logic die_ov,
    // Resolved pin controls.
    output logic pull_en,
    output logic dir,
    output logic value,
    output logic din_en
);

    logic base_pullup;

    // The port pull-up only acts on an input pin and yields to the global disable.
    assign base_pullup = port_out & ~port_dir & ~pull_off;

    // Each control falls back to the port logic when its override enable is low.
    assign pull_en = pu_oe ? pu_ov : base_pullup;
    assign dir = dd_oe ? dd_ov : port_dir;
    assign value = pv_oe ? pv_ov : port_out;
    assign din_en = die_oe ? die_ov : din_base;

endmodule : pde_pin_mux

`default_nettype wire

//--- rtl/pde_override.sv
// Alternate function override logic for port D bits 1:0 and port E bits 7:0.
`timescale 1ns/1ps
`default_nettype none

module pde_override (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Pads of port D bits 1:0.
    input wire logic [1:0] pad_in_d,
    output logic [1:0] port_d_drive,
    output logic [1:0] port_d_oe,
    output logic [1:0] port_d_pullup,
    output logic [1:0] port_d_din_en,
    // Pads of port E bits 7:0.
    input wire logic [7:0] pad_in_e,
    output logic [7:0] port_e_drive,
    output logic [7:0] port_e_oe,
    output logic [7:0] port_e_pullup,
    output logic [7:0] port_e_din_en,
    // Port registers and global controls.
    input wire logic [1:0] out_bits_d,
    input wire logic [1:0] dir_bits_d,
    input wire logic [7:0] out_bits_e,
    input wire logic [7:0] dir_bits_e,
    input wire logic pullup_global_disable,
    input wire logic sleep_din_off,
    input wire logic dev_in_reset,
    // External interrupt and timer capture.
    input wire logic ext_irq_zero_en,
    output logic ext_irq_zero,
    output logic timer_capture_in,
    // Clock output.
    input wire logic clock_out_fuse,
    input wire logic clk_io_div,
    // USART.
    input wire logic usart_sync_mode,
    input wire logic usart_clock_out,
    input wire logic rx_enable,
    input wire logic tx_enable,
    input wire logic tx_data,
    output logic usart_ext_clock,
    output logic rx_data_in,
    // Universal serial interface.
    input wire logic serial_two_wire_mode,
    input wire logic serial_three_wire_mode,
    input wire logic usi_data_out,
    input wire logic clock_line_hold,
    input wire logic clock_toggle_strobe,
    input wire logic start_detect_irq_en,
    output logic usi_serial_in,
    output logic usi_serial_clock,
    // Pin change and analog comparator.
    input wire logic [7:0] pin_change_mask,
    input wire logic pin_change_group0_en,
    input wire logic comparator_neg_din_off,
    input wire logic comparator_pos_din_off,
    output logic [7:0] pin_change_src
);

    localparam int PC = pde_pkg::PIN_COUNT;
    localparam int EB = pde_pkg::E_BASE;

    logic [1:0] sync1_d, sync2_d;
    logic [7:0] sync1_e, sync2_e;
    logic usi_clk_toggle;
    logic armed;
    logic periph_on;
    logic ext_clk_drive;
    logic [7:0] eff_out_e;
    logic [PC-1:0] port_out;
    logic [PC-1:0] port_dir;
    logic [PC-1:0] pu_oe, pu_ov;
    logic [PC-1:0] dd_oe, dd_ov;
    logic [PC-1:0] pv_oe, pv_ov;
    logic [PC-1:0] die_oe, die_ov;
    logic [PC-1:0] next_pullup;
    logic [PC-1:0] next_dir;
    logic [PC-1:0] next_value;
    logic [PC-1:0] next_din_en;
    logic [PC-1:0] pin_level;

    // Pads are asynchronous to the I/O clock, so they pass two flops first.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_d <= pde_pkg::RST_D;
            sync2_d <= pde_pkg::RST_D;
            sync1_e <= pde_pkg::RST_E;
            sync2_e <= pde_pkg::RST_E;
        end else begin
            sync1_d <= pad_in_d;
            sync2_d <= sync1_d;
            sync1_e <= pad_in_e;
            sync2_e <= sync1_e;
        end
    end

    // The serial clock strobe flips a stored toggle that acts on the port bit.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            usi_clk_toggle <= pde_pkg::RST_BIT;
        end else if (clock_toggle_strobe) begin
            usi_clk_toggle <= ~usi_clk_toggle;
        end
    end

    // USART and serial interface pin overrides, except the start-detect input enable, are held off while the device sits in reset.
    assign periph_on = ~dev_in_reset;
    assign ext_clk_drive = periph_on & usart_sync_mode & dir_bits_e[pde_pkg::E_XCLK];

    // Effective port E output bits, with the serial clock toggle folded in.
    assign eff_out_e = out_bits_e ^ (8'(usi_clk_toggle) << pde_pkg::E_USI_CLK);

    assign port_out = {eff_out_e, out_bits_d};
    assign port_dir = {dir_bits_e, dir_bits_d};

    // Override enables and values for every pin; zero means the port rules.
    always_comb begin
        pu_oe = '0;
        pu_ov = '0;
        dd_oe = '0;
        dd_ov = '0;
        pv_oe = '0;
        pv_ov = '0;
        die_oe = '0;
        die_ov = '0;
        // External interrupt input is kept readable while enabled.
        die_oe[pde_pkg::D_EXT_IRQ] = ext_irq_zero_en;
        die_ov[pde_pkg::D_EXT_IRQ] = ext_irq_zero_en;
        // Pin change masks force the digital input on for each port E pin.
        for (int i = 0; i < pde_pkg::E_WIDTH; i++) begin
            die_oe[EB+i] = pin_change_mask[i] & pin_change_group0_en;
            die_ov[EB+i] = 1'b1;
        end
        // Receiver forces bit 0 to input; pull-up follows the port bit.
        pu_oe[EB+pde_pkg::E_RX] = periph_on & rx_enable;
        pu_ov[EB+pde_pkg::E_RX] = out_bits_e[pde_pkg::E_RX] & ~pullup_global_disable;
        dd_oe[EB+pde_pkg::E_RX] = periph_on & rx_enable;
        dd_ov[EB+pde_pkg::E_RX] = 1'b0;
        // Transmitter forces bit 1 to an output carrying the transmit data.
        pu_oe[EB+pde_pkg::E_TX] = periph_on & tx_enable;
        dd_oe[EB+pde_pkg::E_TX] = periph_on & tx_enable;
        dd_ov[EB+pde_pkg::E_TX] = 1'b1;
        pv_oe[EB+pde_pkg::E_TX] = periph_on & tx_enable;
        pv_ov[EB+pde_pkg::E_TX] = tx_data;
        // External USART clock drives bit 2 only in synchronous master use.
        pv_oe[EB+pde_pkg::E_XCLK] = ext_clk_drive;
        pv_ov[EB+pde_pkg::E_XCLK] = usart_clock_out;
        // Comparator inputs may switch the digital input off to save power.
        die_oe[EB+pde_pkg::E_XCLK] = (pin_change_mask[pde_pkg::E_XCLK] & pin_change_group0_en)
            | comparator_pos_din_off;
        die_ov[EB+pde_pkg::E_XCLK] = pin_change_mask[pde_pkg::E_XCLK]
            & pin_change_group0_en;
        die_oe[EB+pde_pkg::E_CMP_NEG] = (pin_change_mask[pde_pkg::E_CMP_NEG]
            & pin_change_group0_en) | comparator_neg_din_off;
        die_ov[EB+pde_pkg::E_CMP_NEG] = pin_change_mask[pde_pkg::E_CMP_NEG]
            & pin_change_group0_en;
        // Two-wire clock: open drain, pulls low on hold or a set port bit.
        pu_oe[EB+pde_pkg::E_USI_CLK] = periph_on & serial_two_wire_mode;
        dd_oe[EB+pde_pkg::E_USI_CLK] = periph_on & serial_two_wire_mode;
        dd_ov[EB+pde_pkg::E_USI_CLK] = (clock_line_hold | eff_out_e[pde_pkg::E_USI_CLK])
            & dir_bits_e[pde_pkg::E_USI_CLK];
        pv_oe[EB+pde_pkg::E_USI_CLK] = periph_on & serial_two_wire_mode
            & dir_bits_e[pde_pkg::E_USI_CLK];
        die_oe[EB+pde_pkg::E_USI_CLK] = die_oe[EB+pde_pkg::E_USI_CLK]
            | start_detect_irq_en;
        // Two-wire data: open drain, pulls low on a set data bit or set port bit.
        pu_oe[EB+pde_pkg::E_USI_DIN] = periph_on & serial_two_wire_mode;
        dd_oe[EB+pde_pkg::E_USI_DIN] = periph_on & serial_two_wire_mode;
        dd_ov[EB+pde_pkg::E_USI_DIN] = (usi_data_out | out_bits_e[pde_pkg::E_USI_DIN])
            & dir_bits_e[pde_pkg::E_USI_DIN];
        pv_oe[EB+pde_pkg::E_USI_DIN] = periph_on & serial_two_wire_mode
            & dir_bits_e[pde_pkg::E_USI_DIN];
        die_oe[EB+pde_pkg::E_USI_DIN] = die_oe[EB+pde_pkg::E_USI_DIN]
            | start_detect_irq_en;
        // Three-wire data out takes over the value; direction stays with the port.
        pv_oe[EB+pde_pkg::E_USI_DOUT] = periph_on & serial_three_wire_mode;
        pv_ov[EB+pde_pkg::E_USI_DOUT] = usi_data_out;
        // Clock output ignores the port direction and value bits and is not gated by device reset.
        dd_oe[EB+pde_pkg::E_CLK_OUT] = clock_out_fuse;
        dd_ov[EB+pde_pkg::E_CLK_OUT] = 1'b1;
        pv_oe[EB+pde_pkg::E_CLK_OUT] = clock_out_fuse;
        pv_ov[EB+pde_pkg::E_CLK_OUT] = clk_io_div;
    end

    // One override multiplexer per pin; capture pin D0 uses only defaults.
    for (genvar g = 0; g < PC; g++) begin : g_pin
        pde_pin_mux u_mux (
            .port_out(port_out[g]),
            .port_dir(port_dir[g]),
            .pull_off(pullup_global_disable),
            .din_base(~sleep_din_off),
            .pu_oe(pu_oe[g]),
            .pu_ov(pu_ov[g]),
            .dd_oe(dd_oe[g]),
            .dd_ov(dd_ov[g]),
            .pv_oe(pv_oe[g]),
            .pv_ov(pv_ov[g]),
            .die_oe(die_oe[g]),
            .die_ov(die_ov[g]),
            .pull_en(next_pullup[g]),
            .dir(next_dir[g]),
            .value(next_value[g]),
            .din_en(next_din_en[g])
        );
    end

    // A disabled digital input reads as zero so a floating analog pad is harmless.
    assign pin_level = {sync2_e, sync2_d} & next_din_en;

    // Pad controls are registered so the pads never see a glitching mux.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port_d_drive <= pde_pkg::RST_D;
            port_d_oe <= pde_pkg::RST_D;
            port_d_pullup <= pde_pkg::RST_D;
            port_d_din_en <= pde_pkg::RST_D;
            port_e_drive <= pde_pkg::RST_E;
            port_e_oe <= pde_pkg::RST_E;
            port_e_pullup <= pde_pkg::RST_E;
            port_e_din_en <= pde_pkg::RST_E;
        end else begin
            port_d_drive <= next_value[1:0];
            port_d_oe <= next_dir[1:0];
            port_d_pullup <= next_pullup[1:0];
            port_d_din_en <= next_din_en[1:0];
            port_e_drive <= next_value[PC-1:EB];
            port_e_oe <= next_dir[PC-1:EB];
            port_e_pullup <= next_pullup[PC-1:EB];
            port_e_din_en <= next_din_en[PC-1:EB];
        end
    end

    // Peripheral inputs taken from the synchronised, gated pin levels.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_irq_zero <= pde_pkg::RST_BIT;
            timer_capture_in <= pde_pkg::RST_BIT;
            usart_ext_clock <= pde_pkg::RST_BIT;
            rx_data_in <= pde_pkg::RST_BIT;
            usi_serial_in <= pde_pkg::RST_BIT;
            usi_serial_clock <= pde_pkg::RST_BIT;
            pin_change_src <= pde_pkg::RST_E;
        end else begin
            ext_irq_zero <= pin_level[pde_pkg::D_EXT_IRQ];
            timer_capture_in <= pin_level[pde_pkg::D_CAPTURE];
            usart_ext_clock <= usart_sync_mode & pin_level[EB+pde_pkg::E_XCLK];
            rx_data_in <= pin_level[EB+pde_pkg::E_RX];
            usi_serial_in <= pin_level[EB+pde_pkg::E_USI_DIN];
            usi_serial_clock <= pin_level[EB+pde_pkg::E_USI_CLK];
            pin_change_src <= pin_level[PC-1:EB];
        end
    end

    // Checks skip the first cycle after reset, when past inputs meet reset outputs.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
        end
    end

    a_irq_pin_din: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(ext_irq_zero_en) |-> port_d_din_en[1])
        else $error("External interrupt pin input not enabled.");

    a_capture_keep: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        port_d_oe[0] == $past(dir_bits_d[0]) && port_d_drive[0] == $past(out_bits_d[0]))
        else $error("Capture pin direction or value was overridden.");

    a_clkout_drive: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(clock_out_fuse) |-> port_e_oe[7] && port_e_drive[7] == $past(clk_io_div))
        else $error("Clock output pin not driving the divided clock.");

    a_clkout_reset: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(clock_out_fuse && dev_in_reset) |-> port_e_oe[7])
        else $error("Clock output stopped during device reset.");

    a_extclk_drive: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(usart_sync_mode && dir_bits_e[2] && !dev_in_reset)
        |-> port_e_oe[2] && port_e_drive[2] == $past(usart_clock_out))
        else $error("External USART clock not driven out.");

    a_extclk_idle: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(!usart_sync_mode) |-> !usart_ext_clock)
        else $error("External USART clock active outside synchronous mode.");

    a_rx_input: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(rx_enable && !dev_in_reset) |-> !port_e_oe[0])
        else $error("Receive pin not forced to input.");

    a_rx_pullup: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(rx_enable && !dev_in_reset)
        |-> port_e_pullup[0] == $past(out_bits_e[0] && !pullup_global_disable))
        else $error("Receive pin pull-up wrong.");

    a_tx_drive: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(tx_enable && !dev_in_reset)
        |-> port_e_oe[1] && !port_e_pullup[1] && port_e_drive[1] == $past(tx_data))
        else $error("Transmit pin not driving transmit data.");

    a_do_value: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(serial_three_wire_mode && !dev_in_reset)
        |-> port_e_drive[6] == $past(usi_data_out) && port_e_oe[6] == $past(dir_bits_e[6]))
        else $error("Serial data output pin wrong in three-wire mode.");

    a_serial_in_din: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(start_detect_irq_en) |-> port_e_din_en[5] && port_e_din_en[4])
        else $error("Serial input disabled while start detect is enabled.");

    a_sda_drain: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(serial_two_wire_mode && !dev_in_reset) |-> !port_e_pullup[5]
        && port_e_oe[5] == $past((usi_data_out || out_bits_e[5]) && dir_bits_e[5])
        && (!port_e_oe[5] || !port_e_drive[5]))
        else $error("Two-wire data pin not open drain.");

    a_scl_drain: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(serial_two_wire_mode && !dev_in_reset) |-> !port_e_pullup[4]
        && port_e_oe[4] == $past((clock_line_hold || eff_out_e[4]) && dir_bits_e[4])
        && (!port_e_oe[4] || !port_e_drive[4]))
        else $error("Two-wire clock pin not open drain.");

    a_clk_toggle: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(clock_toggle_strobe) |-> usi_clk_toggle != $past(usi_clk_toggle))
        else $error("Toggle strobe did not flip the serial clock output.");

    a_pc_din: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(pin_change_mask[7] && pin_change_group0_en) |-> port_e_din_en[7])
        else $error("Pin change input not enabled.");

    a_cmp_neg_off: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(comparator_neg_din_off && !(pin_change_mask[3] && pin_change_group0_en))
        |-> !port_e_din_en[3])
        else $error("Negative comparator pin input not disabled.");

    a_cmp_pos_off: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(comparator_pos_din_off && !(pin_change_mask[2] && pin_change_group0_en))
        |-> !port_e_din_en[2])
        else $error("Positive comparator pin input not disabled.");

    a_tx_fallback: assert property (@(posedge clock) disable iff (!rst_n || !armed)
        $past(!tx_enable) |-> port_e_oe[1] == $past(dir_bits_e[1]))
        else $error("Transmit pin direction not under port control.");

endmodule : pde_override

`default_nettype wire

//--- tb/pde_pad_model.sv
// Pad model for ports D and E as seen from the board side.
`timescale 1ns/1ps
`default_nettype none

module pde_pad_model (
    // Pad controls from the block, port D in bits 1:0.
    input wire logic [9:0] drive,
    input wire logic [9:0] oe,
    // Level the outside world drives on every released pad.
    input wire logic [9:0] ext_level,
    // Resolved pad levels.
    output logic [9:0] pad
);
    // The outside is always driven, so a released pad never floats to an unknown.
    assign pad = (oe & drive) | (~oe & ext_level);
endmodule : pde_pad_model

`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the port D/E override block.
`timescale 1ns/1ps
`default_nettype none

module tb;
    // Stimulus, all given a value at time zero.
    logic clock = 0, rst_n = 0, pullup_global_disable = 0, sleep_din_off = 0;
    logic [1:0] out_bits_d = '0, dir_bits_d = '0;
    logic [7:0] out_bits_e = '0, dir_bits_e = '0, pin_change_mask = '0;
    logic dev_in_reset = 0, ext_irq_zero_en = 0, clock_out_fuse = 0, clk_io_div = 0;
    logic usart_sync_mode = 0, usart_clock_out = 0, rx_enable = 0, tx_enable = 0, tx_data = 0;
    logic serial_two_wire_mode = 0, serial_three_wire_mode = 0, usi_data_out = 0;
    logic clock_line_hold = 0, clock_toggle_strobe = 0, start_detect_irq_en = 0;
    logic pin_change_group0_en = 0, comparator_neg_din_off = 0, comparator_pos_din_off = 0;
    logic [9:0] ext_level = '0;
    // Observed outputs and pads.
    logic [1:0] port_d_drive, port_d_oe, port_d_pullup, port_d_din_en;
    logic [7:0] port_e_drive, port_e_oe, port_e_pullup, port_e_din_en, pin_change_src;
    logic ext_irq_zero, timer_capture_in, usart_ext_clock, rx_data_in;
    logic usi_serial_in, usi_serial_clock;
    wire logic [9:0] pad;
    int err_count = 0, n_checks = 0, cycles = 0;

    pde_override uut (.clock, .rst_n, .pad_in_d(pad[1:0]), .port_d_drive, .port_d_oe,
        .port_d_pullup, .port_d_din_en, .pad_in_e(pad[9:2]), .port_e_drive, .port_e_oe,
        .port_e_pullup, .port_e_din_en, .out_bits_d, .dir_bits_d, .out_bits_e, .dir_bits_e,
        .pullup_global_disable, .sleep_din_off, .dev_in_reset, .ext_irq_zero_en,
        .ext_irq_zero, .timer_capture_in, .clock_out_fuse, .clk_io_div, .usart_sync_mode,
        .usart_clock_out, .rx_enable, .tx_enable, .tx_data, .usart_ext_clock, .rx_data_in,
        .serial_two_wire_mode, .serial_three_wire_mode, .usi_data_out, .clock_line_hold,
        .clock_toggle_strobe, .start_detect_irq_en, .usi_serial_in, .usi_serial_clock,
        .pin_change_mask, .pin_change_group0_en, .comparator_neg_din_off,
        .comparator_pos_din_off, .pin_change_src);

    pde_pad_model pads (.drive({port_e_drive, port_d_drive}), .oe({port_e_oe, port_d_oe}),
        .ext_level, .pad);

    // Free-running 25 MHz clock.
    always #20 clock = ~clock;

    // A hung run is cut short well past the expected length of the tests.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            summarize();
        end
    end

    // Wait a number of edges, then move off the edge so inputs and outputs settle.
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic summarize();
        if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    initial begin
        step(10);
        rst_n = 1;
        // Nothing overriding: pads follow the port registers.
        out_bits_e = 8'hA5;
        dir_bits_e = 8'h3C;
        dir_bits_d = 2'h1;
        out_bits_d = 2'h2;
        step(2);
        chk("e oe", 8'h3C, port_e_oe);
        chk("e drive", 8'hA5, port_e_drive);
        chk("d oe drive", 8'h12, {2'h0, port_d_oe, 2'h0, port_d_drive});
        chk("e pullup", 8'h81, port_e_pullup);
        chk("d pullup", 8'h02, {6'h0, port_d_pullup});
        // Transmitter takes the pin whatever its direction, value and pull-up bits say.
        dir_bits_e = 8'h00;
        out_bits_e = 8'h02;
        tx_enable = 1;
        for (int v = 0; v < 2; v++) begin
            tx_data = v[0];
            step(2);
            chk("tx pin", 8'h02, {6'h0, port_e_oe[1], port_e_pullup[1]});
            chk("tx data", {7'h0, v[0]}, {7'h0, port_e_drive[1]});
        end
        // Receiver forces input; the pull-up follows the port bit and the global disable.
        tx_enable = 0;
        rx_enable = 1;
        dir_bits_e = 8'h01;
        out_bits_e = 8'h01;
        ext_level = 10'h004;
        for (int v = 0; v < 2; v++) begin
            pullup_global_disable = v[0];
            step(4);
            chk("rx pin", {6'h0, ~v[0], 1'b0}, {6'h0, port_e_pullup[0], port_e_oe[0]});
            chk("rx data", 8'h01, {7'h0, rx_data_in});
        end
        // Fuse drives the divided clock on E7, device reset included.
        rx_enable = 0;
        pullup_global_disable = 0;
        dir_bits_e = 8'h00;
        out_bits_e = 8'h00;
        clock_out_fuse = 1;
        dev_in_reset = 1;
        for (int v = 0; v < 2; v++) begin
            clk_io_div = v[0];
            step(2);
            chk("clock out", {v[0], 7'h0}, port_e_drive & port_e_oe);
            chk("clock out oe", 8'h80, port_e_oe);
        end
        clock_out_fuse = 0;
        dev_in_reset = 0;
        // E2 is driven high by its port bit first, then by the USART clock alone.
        dir_bits_e = 8'h04;
        usart_clock_out = 1;
        for (int v = 0; v < 2; v++) begin
            usart_sync_mode = v[0];
            out_bits_e = {5'h0, ~v[0], 2'h0};
            step(4);
            chk("ext clk pin", 8'h04, port_e_drive);
            chk("ext clk in", {7'h0, v[0]}, {7'h0, usart_ext_clock});
        end
        usart_sync_mode = 0;
        // Two-wire mode: open drain data and clock, no pull-ups.
        serial_two_wire_mode = 1;
        clock_line_hold = 1;
        dir_bits_e = 8'h30;
        out_bits_e = 8'h20;
        step(2);
        chk("tw oe", 8'h30, port_e_oe);
        chk("tw drive pull", 8'h00, (port_e_drive | port_e_pullup) & 8'h30);
        // Released lines keep the pull-ups off although the port bits ask for them.
        dir_bits_e = 8'h00;
        out_bits_e = 8'h30;
        step(2);
        chk("tw released", 8'h00, (port_e_oe | port_e_pullup) & 8'h30);
        // Three-wire mode: E6 value from serial data out, direction from the port.
        serial_two_wire_mode = 0;
        serial_three_wire_mode = 1;
        usi_data_out = 1;
        dir_bits_e = 8'h40;
        out_bits_e = 8'h00;
        step(2);
        chk("three wire", 8'h40, port_e_drive & port_e_oe);
        serial_three_wire_mode = 0;
        // A toggle strobe flips the E4 output value.
        clock_toggle_strobe = 1;
        step(1);
        clock_toggle_strobe = 0;
        step(2);
        chk("toggle", 8'h10, port_e_drive & 8'h10);
        // Inputs switched off except where a peripheral needs them.
        dir_bits_e = 8'h00;
        ext_level = 10'h3FF;
        sleep_din_off = 1;
        pin_change_group0_en = 1;
        pin_change_mask = 8'h80;
        start_detect_irq_en = 1;
        ext_irq_zero_en = 1;
        step(4);
        chk("e din", 8'hB0, port_e_din_en);
        chk("pin change", 8'h80, pin_change_src & 8'h80);
        chk("irq usi cap", 8'h06, {5'h0, ext_irq_zero, usi_serial_in, timer_capture_in});
        chk("serial clock", 8'h01, {7'h0, usi_serial_clock});
        chk("d din", 8'h02, {6'h0, port_d_din_en});
        // Comparator disables its inputs unless pin change needs them.
        sleep_din_off = 0;
        start_detect_irq_en = 0;
        ext_irq_zero_en = 0;
        comparator_neg_din_off = 1;
        comparator_pos_din_off = 1;
        pin_change_mask = 8'h04;
        dir_bits_d = 2'h0;
        step(4);
        chk("cmp din", 8'hF7, port_e_din_en);
        chk("capture", 8'h01, {7'h0, timer_capture_in});
        summarize();
    end
endmodule : tb

`default_nettype wire
